/* logic/smpc_pkg.sv */
// shared constants and types of the spread modem parameter block
package smpc_pkg;
    // clock and timing
    localparam int unsigned SYS_CLK_HZ      = 250_000_000; // system clock rate
    localparam int unsigned BW_MAX_HZ       = 500_000;     // widest spread bandwidth
    localparam int unsigned CHIP_BASE_CYC   = SYS_CLK_HZ / BW_MAX_HZ; // cycles per chip at 500k
    // register byte offsets
    localparam logic [7:0]  REG_PROTOCOL    = 8'h00;
    localparam logic [7:0]  REG_MODULATION  = 8'h04;
    localparam logic [7:0]  REG_STATUS      = 8'h08;
    localparam logic [7:0]  REG_TX_HEADER   = 8'h0c;
    localparam logic [7:0]  REG_RX_HEADER   = 8'h10;
    // modulation field positions
    localparam int unsigned MOD_BW_LSB      = 0;  // spread_bandwidth [3:0]
    localparam int unsigned MOD_SF_LSB      = 4;  // spreading_factor [7:4]
    localparam int unsigned MOD_CR_LSB      = 8;  // fec_coding_rate [10:8]
    localparam int unsigned MOD_LOW_RATE_OPTIMIZE_BIT    = 11; // low_rate_optimize
    // header field positions
    localparam int unsigned HDR_LEN_LSB     = 0;  // payload length [7:0]
    localparam int unsigned HDR_CR_LSB      = 8;  // coding rate [10:8]
    localparam int unsigned HDR_CRC_BIT     = 11; // payload check present
    localparam int unsigned HDR_CHK_LSB     = 12; // header check [16:12]
    localparam int unsigned HDR_EXPL_BIT    = 17; // explicit header mode (tx reg only)
    // limits and encodings
    localparam logic [3:0]  SF_MIN          = 4'h5;
    localparam logic [3:0]  SF_MAX          = 4'hc;
    localparam logic [3:0]  BW_CODE_MAX     = 4'h9;
    localparam logic [3:0]  BW_CODE_ZERO_IF = 4'h9; // 500 kHz
    localparam logic [2:0]  CR_MIN          = 3'h1;
    localparam logic [2:0]  CR_MAX          = 3'h4;
    localparam logic [2:0]  CR_HEADER       = 3'h4; // header always at 4/8
    localparam logic [3:0]  FEC_DATA_BITS   = 4'h4;
    localparam logic [3:0]  LOW_RATE_OPTIMIZE_BIT_LOSS   = 4'h2;
    // reset values
    localparam logic [3:0]  RST_BW          = 4'h7; // 125 kHz
    localparam logic [3:0]  RST_SF          = 4'h7;
    localparam logic [2:0]  RST_CR          = 3'h1;
    localparam logic        RST_PROTOCOL    = 1'b0; // fsk
    // protocol selection
    typedef enum logic { SMPC_PROTO_FSK = 1'b0, SMPC_PROTO_SPREAD = 1'b1 } smpc_proto_e;
    // bandwidth divisors of the widest bandwidth, codes 0 to 9
    function automatic logic [6:0] smpc_bw_div(input logic [3:0] code);
        unique case (code)
            4'h0: smpc_bw_div = 7'd64;  // 7.81 kHz
            4'h1: smpc_bw_div = 7'd48;  // 10.42 kHz
            4'h2: smpc_bw_div = 7'd32;  // 15.63 kHz
            4'h3: smpc_bw_div = 7'd24;  // 20.83 kHz
            4'h4: smpc_bw_div = 7'd16;  // 31.25 kHz
            4'h5: smpc_bw_div = 7'd12;  // 41.67 kHz
            4'h6: smpc_bw_div = 7'd8;   // 62.5 kHz
            4'h7: smpc_bw_div = 7'd4;   // 125 kHz
            4'h8: smpc_bw_div = 7'd2;   // 250 kHz
            default: smpc_bw_div = 7'd1; // 500 kHz
        endcase
    endfunction
    // five-bit header check over length, rate and crc flag
    function automatic logic [4:0] smpc_hdr_chk(input logic [11:0] f);
        smpc_hdr_chk = {1'b0, f[3:0]} + {1'b0, f[7:4]} + {1'b0, f[11:8]} + 5'h15;
    endfunction
endpackage

/* logic/smpc_symbol_timer.sv */
// chip and symbol tick generator for the spread modem
`timescale 1ns/10ps
`default_nettype none
module smpc_symbol_timer
    import smpc_pkg::*;
#(
    parameter int unsigned CHIP_BASE_CYCLES = CHIP_BASE_CYC
) (
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       ce_in,
    // settings
    input  wire logic       run_in,
    input  wire logic [3:0] bw_code_in,
    input  wire logic [3:0] sf_in,
    // ticks
    output logic            chip_tick_out,
    output logic            symbol_tick_out
);
    logic [15:0] cyc_q, cyc_d;   // cycles elapsed in current chip
    logic [11:0] chip_q, chip_d; // chips done in current symbol
    logic        ctick_q, ctick_d;
    logic        stick_q, stick_d;
    logic [15:0] chip_len;       // cycles per chip for this bandwidth
    logic [11:0] chips_last;     // 2^sf - 1

    // one chip per second per hertz: chip period = base cycles * divisor
    assign chip_len   = 16'(CHIP_BASE_CYCLES * smpc_bw_div(bw_code_in));
    assign chips_last = 12'((13'h1 << sf_in) - 13'h1);

    // next values of the counters
    always_comb begin
        cyc_d   = cyc_q;
        chip_d  = chip_q;
        ctick_d = 1'b0;
        stick_d = 1'b0;
        if (!run_in) begin
            // idle keeps the counters at the start of a symbol
            cyc_d  = 16'h0000;
            chip_d = 12'h000;
        end else if (cyc_q >= chip_len - 16'h0001) begin
            cyc_d   = 16'h0000;
            ctick_d = 1'b1;
            if (chip_q >= chips_last) begin
                // symbol ends after 2^sf chips
                chip_d  = 12'h000;
                stick_d = 1'b1;
            end else begin
                chip_d = chip_q + 12'h001;
            end
        end else begin
            cyc_d = cyc_q + 16'h0001;
        end
    end

    // registers only
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cyc_q   <= 16'h0000;
            chip_q  <= 12'h000;
            ctick_q <= 1'b0;
            stick_q <= 1'b0;
        end else if (ce_in) begin
            cyc_q   <= cyc_d;
            chip_q  <= chip_d;
            ctick_q <= ctick_d;
            stick_q <= stick_d;
        end
    end

    assign chip_tick_out   = ctick_q;
    assign symbol_tick_out = stick_q;

    // a symbol always closes on a chip boundary
    chk_symbol_on_chip: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        stick_q |-> ctick_q)
        else $error("symbol tick without chip tick");
endmodule
`default_nettype wire

/* logic/smpc_param_config.sv */
// protocol selection and spread modem parameter registers
//
// Functional notes
// - protocol picks frame format and active modem
// - protocol readback returns current selection
// - spreading factor 5..12, 2^sf chips
// - symbol rate is bandwidth over 2^sf
// - sf5 and sf6 allowed with either header
// - bandwidth codes 0..9 map to fixed widths
// - digital baseband mix, zero-if at 500k
// - rate codes 1..4 give 4/5..4/8
// - header carries rate, receiver decodes from it
// - low-rate optimise drops two bits per symbol
// - header sent at 4/8 with own check
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module smpc_param_config
    import smpc_pkg::*;
#(
    parameter int unsigned CHIP_BASE_CYCLES = CHIP_BASE_CYC
) (
    // clock, reset, enable
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    // register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [31:0]      reg_rdata_out,
    // modem run and received header
    input  wire logic        modem_run_in,
    input  wire logic        rx_hdr_valid_in,
    input  wire logic [16:0] rx_hdr_in,
    // modem and frame selection
    output logic             spread_active_out,
    output logic             fsk_active_out,
    // front-end path
    output logic             digital_mix_out,
    output logic             zero_if_out,
    // spread settings to the modem
    output logic [3:0]       spread_bandwidth_out,
    output logic [3:0]       spreading_factor_out,
    output logic [3:0]       bits_per_symbol_out,
    output logic [3:0]       fec_total_bits_out,
    output logic [3:0]       header_total_bits_out,
    output logic [16:0]      tx_header_out,
    output logic [3:0]       rx_payload_bits_out,
    output logic             rx_hdr_bad_out,
    // timing ticks
    output logic             chip_tick_out,
    output logic             symbol_tick_out
);
    // configuration state
    logic        proto_q, proto_d;       // selected protocol
    logic [3:0]  bw_q, bw_d;             // spread_bandwidth code
    logic [3:0]  sf_q, sf_d;             // spreading_factor
    logic [2:0]  cr_q, cr_d;             // fec_coding_rate code
    logic        low_rate_optimize_q, low_rate_optimize_d;         // low_rate_optimize
    logic        reject_q, reject_d;     // last modulation write refused
    logic [7:0]  len_q, len_d;           // tx payload length
    logic        crc_q, crc_d;           // tx payload check present
    logic        expl_q, expl_d;         // explicit header mode
    // receive side state
    logic [2:0]  rxcr_q, rxcr_d;         // rate decoded from last good header
    logic [7:0]  rxlen_q, rxlen_d;       // length from last good header
    logic        rxcrc_q, rxcrc_d;       // crc flag from last good header
    logic        hbad_q, hbad_d;         // corrupt header pulse
    // bus read state
    logic [31:0] rdata_q, rdata_d;
    // helpers
    logic [3:0]  w_bw;
    logic [3:0]  w_sf;
    logic [2:0]  w_cr;
    logic        w_ok;
    logic        mod_wr;
    logic        rx_ok;
    logic [2:0]  pay_cr;
    logic [11:0] tx_fields;
    logic [31:0] status_word;

    // fields of a modulation write
    assign w_bw   = reg_wdata_in[MOD_BW_LSB +: 4];
    assign w_sf   = reg_wdata_in[MOD_SF_LSB +: 4];
    assign w_cr   = reg_wdata_in[MOD_CR_LSB +: 3];
    assign mod_wr = reg_wr_in && (reg_addr_in == REG_MODULATION);
    // every field must be legal, else the whole write is refused
    assign w_ok   = (w_bw <= BW_CODE_MAX) && (w_sf >= SF_MIN) && (w_sf <= SF_MAX)
                    && (w_cr >= CR_MIN) && (w_cr <= CR_MAX);

    // configuration next values
    always_comb begin
        proto_d  = proto_q;
        bw_d     = bw_q;
        sf_d     = sf_q;
        cr_d     = cr_q;
        low_rate_optimize_d   = low_rate_optimize_q;
        reject_d = reject_q;
        len_d    = len_q;
        crc_d    = crc_q;
        expl_d   = expl_q;
        if (reg_wr_in && reg_addr_in == REG_PROTOCOL) begin
            // selection takes effect at once; ordering is the host's duty
            proto_d = reg_wdata_in[0];
        end
        if (mod_wr) begin
            if (w_ok) begin
                // accepted whatever the protocol, so settings can be staged
                bw_d     = w_bw;
                sf_d     = w_sf;
                cr_d     = w_cr;
                low_rate_optimize_d   = reg_wdata_in[MOD_LOW_RATE_OPTIMIZE_BIT];
                reject_d = 1'b0;
            end else begin
                // keep previous setting, flag the refusal
                reject_d = 1'b1;
            end
        end
        if (reg_wr_in && reg_addr_in == REG_TX_HEADER) begin
            // sf5 and sf6 are not barred from either header mode
            len_d  = reg_wdata_in[HDR_LEN_LSB +: 8];
            crc_d  = reg_wdata_in[HDR_CRC_BIT];
            expl_d = reg_wdata_in[HDR_EXPL_BIT];
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            proto_q  <= RST_PROTOCOL;
            bw_q     <= RST_BW;
            sf_q     <= RST_SF;
            cr_q     <= RST_CR;
            low_rate_optimize_q   <= 1'b0;
            reject_q <= 1'b0;
            len_q    <= 8'h00;
            crc_q    <= 1'b0;
            expl_q   <= 1'b1;
        end else if (ce_in) begin
            proto_q  <= proto_d;
            bw_q     <= bw_d;
            sf_q     <= sf_d;
            cr_q     <= cr_d;
            low_rate_optimize_q   <= low_rate_optimize_d;
            reject_q <= reject_d;
            len_q    <= len_d;
            crc_q    <= crc_d;
            expl_q   <= expl_d;
        end
    end

    // header check against corruption
    assign rx_ok = (rx_hdr_in[HDR_CHK_LSB +: 5] == smpc_hdr_chk(rx_hdr_in[11:0]))
                   && (rx_hdr_in[HDR_CR_LSB +: 3] >= CR_MIN)
                   && (rx_hdr_in[HDR_CR_LSB +: 3] <= CR_MAX);

    // receive header next values
    always_comb begin
        rxcr_d  = rxcr_q;
        rxlen_d = rxlen_q;
        rxcrc_d = rxcrc_q;
        hbad_d  = 1'b0;
        if (rx_hdr_valid_in && proto_q == SMPC_PROTO_SPREAD && expl_q) begin
            if (rx_ok) begin
                // payload rate comes from the header, not from setup
                rxcr_d  = rx_hdr_in[HDR_CR_LSB +: 3];
                rxlen_d = rx_hdr_in[HDR_LEN_LSB +: 8];
                rxcrc_d = rx_hdr_in[HDR_CRC_BIT];
            end else begin
                // corrupt header dropped, previous decode kept
                hbad_d = 1'b1;
            end
        end
    end

    // receive header registers
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rxcr_q  <= RST_CR;
            rxlen_q <= 8'h00;
            rxcrc_q <= 1'b0;
            hbad_q  <= 1'b0;
        end else if (ce_in) begin
            rxcr_q  <= rxcr_d;
            rxlen_q <= rxlen_d;
            rxcrc_q <= rxcrc_d;
            hbad_q  <= hbad_d;
        end
    end

    // implicit mode falls back to the configured rate
    assign pay_cr    = expl_q ? rxcr_q : cr_q;
    assign tx_fields = {crc_q, cr_q, len_q};

    // outputs straight from registers or fixed maps of them
    assign spread_active_out     = (proto_q == SMPC_PROTO_SPREAD);
    assign fsk_active_out        = (proto_q == SMPC_PROTO_FSK);
    assign zero_if_out           = spread_active_out && (bw_q == BW_CODE_ZERO_IF);
    assign digital_mix_out       = spread_active_out && (bw_q != BW_CODE_ZERO_IF);
    assign spread_bandwidth_out  = bw_q;
    assign spreading_factor_out  = sf_q;
    assign bits_per_symbol_out   = low_rate_optimize_q ? (sf_q - LOW_RATE_OPTIMIZE_BIT_LOSS) : sf_q;
    assign fec_total_bits_out    = FEC_DATA_BITS + {1'b0, cr_q};
    assign header_total_bits_out = FEC_DATA_BITS + {1'b0, CR_HEADER};
    assign rx_payload_bits_out   = FEC_DATA_BITS + {1'b0, pay_cr};
    assign tx_header_out         = {smpc_hdr_chk(tx_fields), tx_fields};
    assign rx_hdr_bad_out        = hbad_q;

    // status word for software
    assign status_word = {21'h000000, reject_q, fec_total_bits_out[3:0],
                          bits_per_symbol_out, zero_if_out, spread_active_out};

    // read data: one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_d = 32'h00000000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                REG_PROTOCOL:   rdata_d = {31'h00000000, proto_q};
                REG_MODULATION: rdata_d = {20'h00000, low_rate_optimize_q, cr_q, sf_q, bw_q};
                REG_STATUS:     rdata_d = status_word;
                REG_TX_HEADER:  rdata_d = {14'h0000, expl_q, tx_header_out};
                REG_RX_HEADER:  rdata_d = {20'h00000, rxcrc_q, rxcr_q, rxlen_q};
                default:        rdata_d = 32'h00000000; // unmapped reads zero
            endcase
        end
    end

    // read data register
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rdata_q <= 32'h00000000;
        end else if (ce_in) begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata_out = rdata_q;

    // symbol timing runs only while the spread modem is active
    smpc_symbol_timer #(
        .CHIP_BASE_CYCLES (CHIP_BASE_CYCLES)
    ) u_timer (
        .sys_clk_in      (sys_clk_in),
        .sys_rst_in      (sys_rst_in),
        .ce_in           (ce_in),
        .run_in          (modem_run_in && spread_active_out),
        .bw_code_in      (bw_q),
        .sf_in           (sf_q),
        .chip_tick_out   (chip_tick_out),
        .symbol_tick_out (symbol_tick_out)
    );

    // protocol readback matches the last selection written
    chk_proto_readback: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ce_in && reg_rd_in && reg_addr_in == REG_PROTOCOL |=> reg_rdata_out == {31'h0, proto_q})
        else $error("protocol readback wrong");
    // exactly one modem owns the frame at any time
    chk_modem_exclusive: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        spread_active_out != fsk_active_out)
        else $error("both or no modem active");
    // a refused write must leave every field untouched
    chk_invalid_keeps: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ce_in && mod_wr && !w_ok |=> $stable(bw_q) && $stable(sf_q) && $stable(cr_q) && reject_q)
        else $error("invalid modulation changed setting");
    // stored codes never leave their legal range
    chk_sf_range: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        sf_q >= SF_MIN && sf_q <= SF_MAX && bw_q <= BW_CODE_MAX)
        else $error("setting out of range");
    chk_valid_applies: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ce_in && mod_wr && w_ok |=> bw_q == $past(w_bw) && sf_q == $past(w_sf) && !reject_q)
        else $error("valid modulation not applied");
    chk_if_path: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        spread_active_out |-> (zero_if_out == (bw_q == 4'h9)) && (digital_mix_out != zero_if_out))
        else $error("conversion path wrong");
    chk_low_rate_optimize_bits: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        bits_per_symbol_out == (low_rate_optimize_q ? sf_q - 4'h2 : sf_q))
        else $error("bits per symbol wrong");
    // the header always goes out at the strongest rate
    chk_header_rate: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        header_total_bits_out == 4'h8 && fec_total_bits_out == 4'h4 + {1'b0, cr_q})
        else $error("coding rate map wrong");
    // corrupt headers pulse the flag and keep the old decode
    chk_bad_header: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ce_in && rx_hdr_valid_in && spread_active_out && expl_q && !rx_ok
        |=> rx_hdr_bad_out && $stable(rxcr_q))
        else $error("corrupt header not dropped");
    // a good header sets the payload rate for what follows
    chk_rx_rate_used: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ce_in && rx_hdr_valid_in && spread_active_out && expl_q && rx_ok
        |=> rx_payload_bits_out == 4'h4 + {1'b0, $past(rx_hdr_in[10:8])})
        else $error("payload rate not taken from header");
    // read data stands one cycle only, so stale words never look fresh
    chk_rdata_idle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ce_in && !reg_rd_in |=> reg_rdata_out == 32'h00000000)
        else $error("read data not cleared after read cycle");
endmodule
`default_nettype wire

/* tb/smpc_host_model.sv */
// host-side bus master model for the parameter block register port
`timescale 1ns/10ps
`default_nettype none
module smpc_host_model import smpc_pkg::*; (
    // clock
    input  wire logic        sys_clk_in,
    // register port
    output logic [7:0]       reg_addr_out,
    output logic [31:0]      reg_wdata_out,
    output logic             reg_wr_out,
    output logic             reg_rd_out,
    input  wire logic [31:0] reg_rdata_in
);
    // idle bus from time zero
    initial begin
        reg_addr_out  = 8'h00;
        reg_wdata_out = 32'h0;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
    end
    // one-cycle write; data inverted afterwards so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_out  <= a;
        reg_wdata_out <= d;
        reg_wr_out    <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_out    <= 1'b0;
        reg_wdata_out <= ~d;
        #1;
    endtask
    // one-cycle read, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_out <= a;
        reg_rd_out   <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_out   <= 1'b0;
        #1;
        d = reg_rdata_in;
    endtask
    // protocol always goes out before modulation settings
    // preamble, shared sf, band and low_rate_optimize choices are the caller's
    task automatic setup(input logic proto, input logic [31:0] mod);
        wr(REG_PROTOCOL, {31'h0, proto});
        wr(REG_MODULATION, mod);
    endtask
endmodule
`default_nettype wire

/* tb/test_smpc_param_config.sv */
// self-checking bench for the spread modem parameter block
`timescale 1ns/10ps
`default_nettype none
module test_smpc_param_config import smpc_pkg::*; ();
    logic        clk, rst, run, hv, ce;             // clock, reset, modem run, header strobe, enable
    logic [16:0] hdr, txh;                          // rx header in, tx header out
    logic [7:0]  addr;                              // bus address
    logic [31:0] wdata, rdata, d;                   // bus data, last read
    logic        wr, rd, spr, fsk, dmix, zif, hbad, ctick, stick;
    logic [3:0]  bw, sf, bps, fec, hbits, rbits;
    int          errors, n_checks, gaps [3];
    logic [31:0] bad [5], tmw [3];
    // rows: bw sf cr low_rate_optimize | bits per symbol, fec total bits
    logic [23:0] rows [10] = '{24'h051055, 24'h162146, 24'h273077, 24'h384168,
        24'h491095, 24'h5a2186, 24'h6b30b7, 24'h7c41a8, 24'h851135, 24'h9c40c8};
    // clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    smpc_host_model u_host (.sys_clk_in(clk), .reg_addr_out(addr), .reg_wdata_out(wdata),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));
    // base of 1 keeps symbol periods short
    smpc_param_config #(.CHIP_BASE_CYCLES(1)) u_dut (.sys_clk_in(clk), .sys_rst_in(rst),
        .ce_in(ce), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .modem_run_in(run), .rx_hdr_valid_in(hv),
        .rx_hdr_in(hdr), .spread_active_out(spr), .fsk_active_out(fsk),
        .digital_mix_out(dmix), .zero_if_out(zif), .spread_bandwidth_out(bw),
        .spreading_factor_out(sf), .bits_per_symbol_out(bps), .fec_total_bits_out(fec),
        .header_total_bits_out(hbits), .tx_header_out(txh), .rx_payload_bits_out(rbits),
        .rx_hdr_bad_out(hbad), .chip_tick_out(ctick), .symbol_tick_out(stick));
    // compare and count
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // verdict and stop
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // expected header check, worked out independently
    function automatic logic [4:0] hc(input logic [11:0] f);
        hc = f[3:0] + f[7:4] + f[11:8] + 5'h15;
    endfunction
    // one received header pulse, outputs settle one cycle later
    task automatic rxh(input logic [16:0] h);
        @(posedge clk);
        hv  <= 1'b1;
        hdr <= h;
        @(posedge clk);
        hv  <= 1'b0;
        hdr <= ~h;
        #1;
    endtask
    // cycles between two symbol ticks, bounded waits
    task automatic sym_gap(input int exp, input int expc);
        int n;
        int c;
        n = 0;
        c = 0;
        while (stick !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            c += ctick;
        end while (stick !== 1'b1 && n < 5000);
        check("symbol_gap", n, exp);
        check("chip_count", c, expc);
    endtask
    // watchdog, far beyond the expected run
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
    initial begin
        errors = 0;
        n_checks = 0;
        rst = 1'b1;
        run = 1'b0;
        hv = 1'b0;
        ce = 1'b1;
        hdr = 17'h0;
        bad = '{32'h04ca, 32'h0449, 32'h04d9, 32'h00c9, 32'h05c9};
        tmw = '{32'h0158, 32'h0159, 32'h0967};
        gaps = '{64, 32, 256};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // reset state and unmapped read
        u_host.rd(REG_PROTOCOL, d);
        check("proto_reset", d, 32'h0);
        check("fsk_reset", {spr, fsk}, 2'b01);
        u_host.rd(8'h20, d);
        check("unmapped", d, 32'h0);
        // table of legal settings
        for (int i = 0; i < 10; i++) begin
            u_host.setup(1'b1, {20'h0, rows[i][8], rows[i][14:12], rows[i][19:16], rows[i][23:20]});
            check("bw", bw, rows[i][23:20]);
            check("sf", sf, rows[i][19:16]);
            check("bps", bps, rows[i][7:4]);
            check("fec", fec, rows[i][3:0]);
            check("path", {dmix, zif}, (rows[i][23:20] == 4'h9) ? 2'b01 : 2'b10);
            u_host.rd(REG_STATUS, d);
            check("status", d, {22'h0, rows[i][3:0], rows[i][7:4], rows[i][23:20] == 4'h9, 1'b1});
        end
        u_host.rd(REG_PROTOCOL, d);
        check("proto_rb", d, 32'h1);
        check("spread", {spr, fsk}, 2'b10);
        // illegal codes leave the setting alone
        foreach (bad[i]) begin
            u_host.wr(REG_MODULATION, bad[i]);
            check("kept", {bw, sf, fec}, 12'h9c8);
            u_host.rd(REG_STATUS, d);
            check("reject", d[10], 1'b1);
        end
        u_host.wr(REG_MODULATION, 32'h0357);
        u_host.rd(REG_STATUS, d);
        check("reject_clr", {d[10], fec}, 5'h07);
        // transmit header carries the rate and its own check
        u_host.wr(REG_TX_HEADER, 32'h000208a5);
        check("txh", txh, {hc(12'hba5), 12'hba5});
        check("hdr_bits", hbits, 4'h8);
        u_host.rd(REG_TX_HEADER, d);
        check("txh_rb", d, {14'h0, 1'b1, hc(12'hba5), 12'hba5});
        // received headers, good then corrupted
        rxh({hc(12'h210), 12'h210});
        check("rx_good", {hbad, rbits}, 5'h06);
        rxh({hc(12'h440) + 5'h1, 12'h440});
        check("rx_badchk", {hbad, rbits}, 5'h16);
        rxh({hc(12'h010), 12'h010});
        check("rx_badcr", {hbad, rbits}, 5'h16);
        u_host.rd(REG_RX_HEADER, d);
        check("rx_rb", d, 32'h210);
        u_host.wr(REG_TX_HEADER, 32'h0);
        check("implicit", rbits, 4'h7);
        u_host.wr(REG_PROTOCOL, 32'h0);
        check("fsk_sel", {spr, fsk, dmix, zif}, 4'b0100);
        // symbol timing at several bandwidths and factors
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            run <= 1'b0;
            u_host.setup(1'b1, tmw[i]);
            @(posedge clk);
            run <= 1'b1;
            sym_gap(gaps[i], 1 << tmw[i][7:4]);
        end
        // enable low freezes the settings, then full readback of the last ones
        @(posedge clk);
        ce <= 1'b0;
        u_host.wr(REG_MODULATION, 32'h0158);
        check("ce_hold", {bw, sf}, 8'h76);
        @(posedge clk);
        ce <= 1'b1;
        u_host.rd(REG_MODULATION, d);
        check("mod_rb", d, 32'h0967);
        // second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("rerst", {fsk, bw, sf}, 9'h177);
        end_of_test();
    end
endmodule
`default_nettype wire
